// ===== logic/spc_pkg.sv
// Package: shared constants and types of the serial speech control block
// ============================================================================
// Notes on behaviour
// - Serial input accepted only while select low
// - Bit order and clock idle from stored data
// - Permission output high when input accepted
// - Busy goes low once event fixed
// - Busy returns high after post-playback wait
// - Click suppression after busy high, then standby
// - Fault high on disconnection or overtemperature
// - Disconnection checked only for event one
// - 100 ms fault pulse at event start
// - Amplifier off while disable input high
// - At most 62 selectable events
// - Volume quantised to 32 steps, one mute
// - Sample rate chosen per phrase
// - Coding scheme chosen per phrase
// - Samples delivered to 16-bit converter
// ============================================================================
`default_nettype none
package spc_pkg;

  // ==========================================================================
  // Serial command word
  localparam int          WORD_W       = 8;     // Bits per command word
  localparam int          OP_MSB       = 7;     // Opcode field position
  localparam int          OP_LSB       = 6;
  localparam int          EVT_W        = 6;     // Event number field width
  localparam logic [1:0]  OP_PLAY      = 2'h0;  // Start an event
  localparam logic [1:0]  OP_STOP      = 2'h1;  // Abort playback
  localparam logic [5:0]  EVT_FIRST    = 6'h01; // Lowest event number
  localparam logic [5:0]  EVT_LAST     = 6'h3E; // Highest event number (62)
  localparam logic [5:0]  EVT_DISCON   = 6'h01; // Event that checks the speaker

  // ==========================================================================
  // Audio path
  localparam int          SAMPLE_W     = 16;    // Converter width
  localparam int          VOL_RAW_W    = 10;    // Volume converter code width
  localparam int          VOL_STEP_W   = 5;     // 32 volume steps
  localparam logic [4:0]  VOL_MUTE     = 5'h00; // Step that mutes
  localparam logic [15:0] DAC_IDLE     = 16'h0000;

  // ==========================================================================
  // Timing, in the units printed
  localparam int          CLK_HZ       = 100_000_000;
  localparam int          FAULT_PULSE_MS = 100; // Fault pulse at event start
  localparam int          WAIT_US      = 10;    // Post-playback wait
  localparam int          POP_MS       = 10;    // Click suppression time
  localparam int          TIMER_W      = 24;

  // ==========================================================================
  // Phrase coding schemes
  typedef enum logic [2:0] {
    CODE_ADPCM4 = 3'h0,
    CODE_PCM8   = 3'h1,
    CODE_PCM16  = 3'h2,
    CODE_NLPCM8 = 3'h3,
    CODE_HQ     = 3'h4
  } spc_coding_t;

  // Phrase sampling rates
  typedef enum logic [2:0] {
    RATE_8K0  = 3'h0,
    RATE_16K0 = 3'h1,
    RATE_32K0 = 3'h2,
    RATE_6K4  = 3'h3,
    RATE_12K8 = 3'h4,
    RATE_25K6 = 3'h5,
    RATE_10K7 = 3'h6,
    RATE_21K3 = 3'h7
  } spc_rate_t;

  // Playback sequencer states
  typedef enum logic [2:0] {
    ST_STANDBY = 3'h0,
    ST_FIX     = 3'h1,
    ST_PLAY    = 3'h2,
    ST_WAIT    = 3'h3,
    ST_POP     = 3'h4
  } spc_state_t;

endpackage
`default_nettype wire

// ===== logic/spc_link_if.sv
// Interface: received serial word passed from the link domain to the core
`timescale 1ns/100ps
`default_nettype none
interface spc_link_if;
  logic [7:0] word;         // Last complete word, stable until next one
  logic       word_toggle;  // Flips once per completed word
  modport rx   (output word, output word_toggle);
  modport core (input  word, input  word_toggle);
endinterface
`default_nettype wire

// ===== logic/spc_serial_rx.sv
// Module: serial word receiver running on the host's serial clock
`timescale 1ns/100ps
`default_nettype none
module spc_serial_rx (
  input  wire logic i_serial_clock,      // Host serial clock
  input  wire logic i_serial_select_low, // Chip select, active low
  input  wire logic i_serial_data_in,    // Serial data
  input  wire logic i_cfg_idle_high,     // Clock idles high (static strap)
  input  wire logic i_arst_n,            // Device reset, active low
  spc_link_if.rx    link                 // Word towards the core
);

  // ==========================================================================
  // Sampling clock
  // Inverting for a high idle makes the first edge after idle the rising one
  // of this clock; the strap must not change while select is low
  wire logic       sample_clk;
  logic      [2:0] bit_cnt_reg;          // Bits held in shift register
  logic      [6:0] shift_reg;            // Partial word
  logic      [7:0] word_reg;             // Last full word
  logic            toggle_reg;           // Word completion marker

  assign sample_clk = i_serial_clock ^ i_cfg_idle_high;

  // ==========================================================================
  // Shift and count; select high clears a partial word at once
  always_ff @(posedge sample_clk or posedge i_serial_select_low) begin
    if (i_serial_select_low) begin
      bit_cnt_reg <= 3'h0;
      shift_reg   <= 7'h00;
    end else begin
      shift_reg   <= {shift_reg[5:0], i_serial_data_in};
      bit_cnt_reg <= bit_cnt_reg + 3'h1; // Wraps after eight bits
    end
  end

  // ==========================================================================
  // Hand over the finished word; not cleared by select so it survives
  always_ff @(posedge sample_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      word_reg   <= 8'h00;
      toggle_reg <= 1'b0;
    end else if (!i_serial_select_low && bit_cnt_reg == 3'h7) begin
      word_reg   <= {shift_reg, i_serial_data_in};
      toggle_reg <= ~toggle_reg;
    end
  end

  assign link.word        = word_reg;
  assign link.word_toggle = toggle_reg;

endmodule // spc_serial_rx
`default_nettype wire

// ===== logic/spc_top.sv
// Module: serial control and playback sequencer of the speech device
`timescale 1ns/100ps
`default_nettype none
module spc_top #(
  parameter int P_CLK_HZ         = spc_pkg::CLK_HZ,
  // Long counts, shortened in simulation
  parameter int P_FAULT_PULSE_CYC = spc_pkg::FAULT_PULSE_MS * (spc_pkg::CLK_HZ / 1000),
  parameter int P_WAIT_CYC        = spc_pkg::WAIT_US * (spc_pkg::CLK_HZ / 1_000_000),
  parameter int P_POP_CYC         = spc_pkg::POP_MS * (spc_pkg::CLK_HZ / 1000)
) (
  input  wire logic        i_core_clk,           // Device clock, 100 MHz
  input  wire logic        i_arst_n,             // Reset pin, active low
  // Serial link
  input  wire logic        i_serial_clock,       // Host serial clock
  input  wire logic        i_serial_select_low,  // Chip select, active low
  input  wire logic        i_serial_data_in,     // Serial data
  output logic             o_clock_permission_out, // Serial input permitted
  output logic             o_playback_active_low,  // Busy, active low
  output logic             o_fault,              // Fault flag
  // Stored data configuration
  input  wire logic        i_cfg_msb_first,      // Strap: word arrives MSB first
  input  wire logic        i_cfg_clk_idle_high,  // Strap: serial clock idles high
  // Phrase store and decoder
  output logic [5:0]       o_event_number,       // Selected event
  output logic [2:0]       o_coding_sel,         // Coding scheme of the phrase
  output logic [2:0]       o_rate_sel,           // Sample rate of the phrase
  output logic             o_sample_req,         // Pulse: decoder shall give a sample
  input  wire logic [2:0]  i_phrase_coding,      // Coding of o_event_number
  input  wire logic [2:0]  i_phrase_rate,        // Rate of o_event_number
  input  wire logic [15:0] i_sample,             // Decoded sample, signed
  input  wire logic        i_sample_valid,       // Sample strobe
  input  wire logic        i_phrase_done,        // Pulse: phrase finished
  // Analogue side
  input  wire logic [9:0]  i_volume_code,        // Volume converter code
  input  wire logic        i_amplifier_disable,  // Amplifier off pin
  input  wire logic        i_speaker_open,       // Speaker disconnection sense
  input  wire logic        i_over_temp,          // Die above threshold
  output logic [15:0]      o_dac_data,           // Converter input word
  output logic             o_amp_enable,         // Speaker amplifier on
  output logic             o_standby             // Device in standby
);

  // ==========================================================================
  // Reset release
  logic                rst_s1_reg;               // First release stage
  logic                rst_n;                    // Released reset copy

  // Release two edges after the pin, assert at once
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_s1_reg <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n      <= rst_s1_reg;
    end
  end

  // ==========================================================================
  // Link domain receiver
  spc_link_if link_bus ();
  spc_serial_rx spc_serial_rx_i (
    .i_serial_clock      (i_serial_clock),
    .i_serial_select_low (i_serial_select_low),
    .i_serial_data_in    (i_serial_data_in),
    .i_cfg_idle_high     (i_cfg_clk_idle_high),
    .i_arst_n            (i_arst_n),
    .link                (link_bus.rx)
  );

  // ==========================================================================
  // Pin synchronisers
  logic [4:0]          pin_s1_reg;               // First stage, read by second only
  logic [4:0]          pin_s2_reg;               // Usable copies
  logic                tog_s3_reg;               // Previous word toggle
  wire logic           cs_high_s;                // Select released
  wire logic           amp_off_s;                // Amplifier disable
  wire logic           open_s;                   // Speaker open
  wire logic           hot_s;                    // Over temperature
  wire logic           tog_s;                    // Word toggle
  wire logic           word_evt;                 // New word arrived

  // All asynchronous inputs pass two flip-flops
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_reg <= 5'h01;
      pin_s2_reg <= 5'h01;
      tog_s3_reg <= 1'b0;
    end else begin
      pin_s1_reg <= {link_bus.word_toggle, i_over_temp, i_speaker_open,
                     i_amplifier_disable, i_serial_select_low};
      pin_s2_reg <= pin_s1_reg;
      tog_s3_reg <= pin_s2_reg[4];
    end
  end

  assign cs_high_s = pin_s2_reg[0];
  assign amp_off_s = pin_s2_reg[1];
  assign open_s    = pin_s2_reg[2];
  assign hot_s     = pin_s2_reg[3];
  assign tog_s     = pin_s2_reg[4];
  assign word_evt  = tog_s ^ tog_s3_reg;

  // ==========================================================================
  // Strap capture after reset release
  logic                strap_s1_reg;             // First stage
  logic                strap_s2_reg;             // Second stage
  logic [1:0]          strap_cnt_reg;            // Edges since release, stops at 3
  logic                msb_first_reg;            // Bit order in use

  // Taken on each of the first three edges after release, then frozen
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_s1_reg   <= 1'b1;
      strap_s2_reg   <= 1'b1;
      strap_cnt_reg  <= 2'h0;
      msb_first_reg  <= 1'b1;
    end else begin
      strap_s1_reg <= i_cfg_msb_first;
      strap_s2_reg <= strap_s1_reg;
      if (strap_cnt_reg != 2'h3) begin
        strap_cnt_reg <= strap_cnt_reg + 2'h1;   // Last take on third edge, when s2 holds the pin
        msb_first_reg <= strap_s2_reg;
      end
    end
  end

  // ==========================================================================
  // Command word
  spc_pkg::spc_state_t state_reg;                // Sequencer state
  spc_pkg::spc_state_t state_next;
  logic [7:0]          cmd;                      // Word in MSB-first order
  logic                permit;                   // Permission level
  logic                drop_reg;                 // Word overlapped a refusal
  wire logic           cmd_ok;                   // Word may be obeyed
  wire logic [1:0]     cmd_op;                   // Opcode
  wire logic [5:0]     cmd_evt;                  // Event number field
  wire logic           play_cmd;                 // Valid event request
  wire logic           stop_cmd;                 // Stop request

  // Reverse the word when it arrives LSB first
  always_comb begin
    cmd = link_bus.word;
    if (!msb_first_reg) begin
      for (int i = 0; i < spc_pkg::WORD_W; i++) begin
        cmd[i] = link_bus.word[spc_pkg::WORD_W - 1 - i];
      end
    end
  end

  // Input is permitted in standby and while playing, not during fixing,
  // waiting or click suppression
  assign permit = (state_reg == spc_pkg::ST_STANDBY) ||
                  (state_reg == spc_pkg::ST_PLAY);

  // A word that was clocked in while permission was low is thrown away
  // whole; the mark lasts until select rises
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      drop_reg <= 1'b0;
    end else if (!permit && !cs_high_s) begin
      drop_reg <= 1'b1;
    end else if (cs_high_s) begin
      drop_reg <= 1'b0;
    end
  end

  assign cmd_ok   = word_evt && permit && !drop_reg;
  assign cmd_op   = cmd[spc_pkg::OP_MSB:spc_pkg::OP_LSB];
  assign cmd_evt  = cmd[spc_pkg::EVT_W-1:0];
  assign play_cmd = cmd_ok && (cmd_op == spc_pkg::OP_PLAY) &&
                    (state_reg == spc_pkg::ST_STANDBY) &&
                    (cmd_evt >= spc_pkg::EVT_FIRST) &&
                    (cmd_evt <= spc_pkg::EVT_LAST);
  assign stop_cmd = cmd_ok && (cmd_op == spc_pkg::OP_STOP) &&
                    (state_reg == spc_pkg::ST_PLAY);

  // ==========================================================================
  // Playback sequencer
  logic [23:0]         timer_reg;                // Wait and suppression timer
  wire logic           timer_done;               // Timer expired
  assign timer_done = (timer_reg == 24'h000000);

  // Next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      spc_pkg::ST_STANDBY: begin
        if (play_cmd) begin
          state_next = spc_pkg::ST_FIX;
        end
      end
      spc_pkg::ST_FIX: begin
        state_next = spc_pkg::ST_PLAY;
      end
      spc_pkg::ST_PLAY: begin
        if (i_phrase_done || stop_cmd) begin
          state_next = spc_pkg::ST_WAIT;
        end
      end
      spc_pkg::ST_WAIT: begin
        if (timer_done) begin
          state_next = spc_pkg::ST_POP;
        end
      end
      spc_pkg::ST_POP: begin
        if (timer_done) begin
          state_next = spc_pkg::ST_STANDBY;
        end
      end
      default: begin
        state_next = spc_pkg::ST_STANDBY;        // Illegal codes recover
      end
    endcase
  end

  // State register
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= spc_pkg::ST_STANDBY;
    end else begin
      state_reg <= state_next;
    end
  end

  // Timer loads on entry to each timed state, counts down inside it
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_reg <= 24'h000000;
    end else if (state_reg == spc_pkg::ST_PLAY && state_next == spc_pkg::ST_WAIT) begin
      timer_reg <= 24'(P_WAIT_CYC - 1);
    end else if (state_reg == spc_pkg::ST_WAIT && timer_done) begin
      timer_reg <= 24'(P_POP_CYC - 1);
    end else if (!timer_done) begin
      timer_reg <= timer_reg - 24'h000001;
    end
  end

  // ==========================================================================
  // Event selection and phrase options
  // Event number is latched with the command; coding and rate in the fixing cycle, when the store shows the event
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_event_number <= 6'h00;
      o_coding_sel   <= 3'h0;
      o_rate_sel     <= 3'h0;
    end else if (play_cmd) begin
      o_event_number <= cmd_evt;
    end else if (state_reg == spc_pkg::ST_FIX) begin
      o_coding_sel   <= i_phrase_coding;
      o_rate_sel     <= i_phrase_rate;
    end
  end

  // ==========================================================================
  // Sample pacing
  logic [15:0]         rate_cnt_reg;             // Cycles left in sample period
  logic [15:0]         rate_period;              // Cycles per sample
  // Period in cycles for the phrase rate
  always_comb begin
    unique case (spc_pkg::spc_rate_t'(o_rate_sel))
      spc_pkg::RATE_8K0:  rate_period = 16'(P_CLK_HZ / 8000);
      spc_pkg::RATE_16K0: rate_period = 16'(P_CLK_HZ / 16000);
      spc_pkg::RATE_32K0: rate_period = 16'(P_CLK_HZ / 32000);
      spc_pkg::RATE_6K4:  rate_period = 16'(P_CLK_HZ / 6400);
      spc_pkg::RATE_12K8: rate_period = 16'(P_CLK_HZ / 12800);
      spc_pkg::RATE_25K6: rate_period = 16'(P_CLK_HZ / 25600);
      spc_pkg::RATE_10K7: rate_period = 16'(P_CLK_HZ / 10700);
      spc_pkg::RATE_21K3: rate_period = 16'(P_CLK_HZ / 21300);
    endcase
  end

  // One request per sample period while playing
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rate_cnt_reg <= 16'h0000;
      o_sample_req <= 1'b0;
    end else if (state_reg != spc_pkg::ST_PLAY) begin
      rate_cnt_reg <= 16'h0000;
      o_sample_req <= 1'b0;
    end else if (rate_cnt_reg == 16'h0000) begin
      rate_cnt_reg <= rate_period - 16'h0001;
      o_sample_req <= 1'b1;
    end else begin
      rate_cnt_reg <= rate_cnt_reg - 16'h0001;
      o_sample_req <= 1'b0;
    end
  end

  // ==========================================================================
  // Volume and converter word
  wire logic [4:0]     vol_step;                 // One of 32 steps
  logic signed [21:0]  scaled;                   // Sample times step
  // Top bits of the converter code pick the step
  assign vol_step = i_volume_code[spc_pkg::VOL_RAW_W-1 -: spc_pkg::VOL_STEP_W];
  // Full scale is 31/32 of the sample; a true unity gain would cost a divider
  assign scaled   = $signed(i_sample) * $signed({1'b0, vol_step});

  // Converter word follows the decoder in play unless muted, rests at idle otherwise
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_dac_data <= spc_pkg::DAC_IDLE;
    end else if (state_reg != spc_pkg::ST_PLAY || vol_step == spc_pkg::VOL_MUTE) begin
      o_dac_data <= spc_pkg::DAC_IDLE;
    end else if (i_sample_valid) begin
      o_dac_data <= scaled[20:5];
    end
  end

  // ==========================================================================
  // Fault reporting
  logic [23:0]         pulse_cnt_reg;            // Start pulse remaining
  logic                discon_reg;               // Disconnection latched

  // Start pulse counts from the fixing cycle
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_cnt_reg <= 24'h000000;
    end else if (state_reg == spc_pkg::ST_FIX) begin
      pulse_cnt_reg <= 24'(P_FAULT_PULSE_CYC);
    end else if (pulse_cnt_reg != 24'h000000) begin
      pulse_cnt_reg <= pulse_cnt_reg - 24'h000001;
    end
  end

  // Speaker checked only under the dedicated event, kept until next start
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      discon_reg <= 1'b0;
    end else if (state_reg == spc_pkg::ST_PLAY && o_event_number == spc_pkg::EVT_DISCON
                 && open_s) begin
      discon_reg <= 1'b1;
    end else if (state_reg == spc_pkg::ST_FIX) begin
      discon_reg <= 1'b0;
    end
  end

  // Fault output is registered
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_fault <= 1'b0;
    end else begin
      o_fault <= discon_reg || hot_s || (pulse_cnt_reg != 24'h000000);
    end
  end

  // ==========================================================================
  // Status outputs
  // Busy low from fixing through the wait, high again for suppression
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_playback_active_low <= 1'b1;
      o_standby             <= 1'b1;
      o_amp_enable          <= 1'b0;
    end else begin
      o_playback_active_low <= !(state_next == spc_pkg::ST_FIX ||
                                 state_next == spc_pkg::ST_PLAY ||
                                 state_next == spc_pkg::ST_WAIT);
      o_standby             <= (state_next == spc_pkg::ST_STANDBY);
      o_amp_enable          <= !amp_off_s && (state_next == spc_pkg::ST_PLAY ||
                                              state_next == spc_pkg::ST_WAIT);
    end
  end

  // Permission is a handshake level straight from the state
  assign o_clock_permission_out = permit;

endmodule // spc_top
`default_nettype wire

// ===== sim/spc_sva.sv
// Checker: port timing relations of the serial speech control block
`timescale 1ns/100ps
`default_nettype none
module spc_sva (
  input wire logic       i_core_clk, i_arst_n, i_amplifier_disable, i_over_temp,
  input wire logic       o_clock_permission_out, o_playback_active_low, o_fault,
  input wire logic       o_standby, o_amp_enable,
  input wire logic [5:0] o_event_number
);
  // ======
  // One core domain, quiet while the reset pin is low
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  property p_fix_locks; $fell(o_playback_active_low) |-> !o_clock_permission_out; endproperty
  a_fix_locks: assert property (p_fix_locks) else $error("permission high at fix");
  property p_evt_range; $fell(o_playback_active_low) |-> o_event_number inside {[1:62]}; endproperty
  a_evt_range: assert property (p_evt_range) else $error("event out of range");
  property p_start_pulse; $fell(o_playback_active_low) |-> ##2 o_fault [*8]; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("no start pulse");
  property p_fix_hold; !o_clock_permission_out && !o_playback_active_low |=> $stable(o_event_number); endproperty
  a_fix_hold: assert property (p_fix_hold) else $error("event changed while locked");
  property p_idle; o_standby |-> o_playback_active_low && !o_amp_enable; endproperty
  a_idle: assert property (p_idle) else $error("standby while busy");
  property p_pop_seq; $rose(o_playback_active_low) |-> !o_standby [*8] ##[1:20] o_standby; endproperty
  a_pop_seq: assert property (p_pop_seq) else $error("bad click suppression");
  // Six cycles cover reset sync, pin sync and output register
  property p_amp_off; i_amplifier_disable [*6] |-> !o_amp_enable; endproperty
  a_amp_off: assert property (p_amp_off) else $error("amplifier on while disabled");
  property p_hot; i_over_temp [*6] |-> o_fault; endproperty
  a_hot: assert property (p_hot) else $error("no overtemperature fault");
  c_play: cover property ($fell(o_playback_active_low));
  c_idle: cover property ($rose(o_standby));
  c_hot: cover property (i_over_temp ##6 o_fault);
endmodule // spc_sva
bind spc_top spc_sva spc_sva_i (.i_core_clk, .i_arst_n, .i_amplifier_disable, .i_over_temp,
  .o_clock_permission_out, .o_playback_active_low, .o_fault, .o_standby, .o_amp_enable,
  .o_event_number);
`default_nettype wire

// ===== sim/spc_host.sv
// Partner: host controller driving the serial command link
`timescale 1ns/100ps
`default_nettype none
module spc_host (
  input  wire logic i_perm,
  output logic      o_sclk, o_sel_n, o_sdi
);
  // ======
  // Clock stands still low between frames, select idles high
  initial begin
    o_sclk = 1'b0;
    o_sel_n = 1'b1;
    o_sdi = 1'b0;
  end
  // Sends top n bits of w MSB first, 32 ns a bit
  task automatic send(input logic [7:0] w, input int n);
    int k;
    wait (i_perm === 1'b1);
    #7 o_sel_n = 1'b0;
    for (k = 7; k > 7 - n; k--) begin
      o_sdi = w[k];
      #16 o_sclk = 1'b1;
      #16 o_sclk = 1'b0;
    end
    #16 o_sel_n = 1'b1;
    o_sdi = ~o_sdi; // Released line must not echo the last bit
  endtask
endmodule // spc_host
`default_nettype wire

// ===== sim/speech_player_serial_control_tb.sv
// Testbench: playback, refusals and fault paths of the speech control block
`timescale 1ns/100ps
`default_nettype none
module speech_player_serial_control_tb;
  logic        clk = 1'b0, rst_n = 1'b0, amp_off = 1'b0, hot = 1'b0, spk = 1'b0;
  logic        done = 1'b0, vld = 1'b0, alt = 1'b0;
  logic [15:0] smp = 16'h4000;
  logic [9:0]  vol = 10'h3FF;
  logic [2:0]  cod = 3'h0, rate = 3'h0, cs, rs;
  logic        perm, busy_n, fault, stby, amp, req;
  logic [5:0]  evt;
  logic [15:0] dac;
  logic [13:0] rows [8];   // Command, coding, rate
  wire logic   sclk, sel_n, sdi;
  int          num_errors = 0, n_compared = 0, i;
  spc_top #(.P_FAULT_PULSE_CYC(50), .P_WAIT_CYC(10), .P_POP_CYC(20)) spc_top_i (
    .i_core_clk(clk), .i_arst_n(rst_n), .i_serial_clock(sclk ^ alt), .i_serial_select_low(sel_n),
    .i_serial_data_in(sdi), .o_clock_permission_out(perm), .o_playback_active_low(busy_n),
    .o_fault(fault), .i_cfg_msb_first(!alt), .i_cfg_clk_idle_high(alt),
    .o_event_number(evt), .o_coding_sel(cs), .o_rate_sel(rs), .o_sample_req(req),
    .i_phrase_coding(cod), .i_phrase_rate(rate), .i_sample(smp), .i_sample_valid(vld),
    .i_phrase_done(done), .i_volume_code(vol), .i_amplifier_disable(amp_off),
    .i_speaker_open(spk), .i_over_temp(hot), .o_dac_data(dac), .o_amp_enable(amp),
    .o_standby(stby));
  spc_host spc_host_i (.i_perm(perm), .o_sclk(sclk), .o_sel_n(sel_n), .o_sdi(sdi));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Bounded wait for busy (s=0) or standby (s=1) to reach v
  task automatic wt(input bit s, input logic v, input int n);
    repeat (n) if ((s ? stby : busy_n) !== v) @(posedge clk);
  endtask
  task automatic end_sim;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Sends w, expects a fix, checks the event and settles in play
  task automatic play(input logic [7:0] w);
    spc_host_i.send(w, 8);
    wt(0, 1'b0, 20);
    chk(busy_n, 1'b0);
    chk(evt, w[5:0]);
    repeat (3) @(posedge clk);
  endtask
  initial begin
    for (i = 0; i < 8; i++) rows[i] = {2'h0, (i == 7) ? 6'h3E : 6'(1 + i * 8), 3'(i % 5), 3'(i)};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk(stby, 1'b1);
    for (i = 0; i < 8; i++) begin
      {cod, rate} <= rows[i][5:0];
      play(rows[i][13:6]);
      chk({cs, rs}, rows[i][5:0]);
      chk(fault, 1'b1);
      chk(req, 1'b1);
      vld <= 1'b1;
      @(posedge clk) vld <= 1'b0;
      @(posedge clk) chk(dac, 16'h3E00);
      @(posedge clk) done <= 1'b1;
      @(posedge clk) done <= 1'b0;
      wt(1, 1'b1, 100);
      chk(stby, 1'b1);
    end
    // Refused words: events 0 and 63, a stop in standby, an unused opcode, then a cut word
    foreach (rows[j]) if (j < 4) begin
      spc_host_i.send(j[1] ? {j[0], 7'h41} : {2'h0, {6{j[0]}}}, 8);
      repeat (20) @(posedge clk);
      chk(busy_n, 1'b1);
    end
    spc_host_i.send(8'h08, 5);
    spk <= 1'b1;
    play(8'h05);
    repeat (60) @(posedge clk);
    chk(fault, 1'b0);
    chk(amp, 1'b1);
    amp_off <= 1'b1;
    hot <= 1'b1;
    repeat (6) @(posedge clk);
    chk(amp, 1'b0);
    chk(fault, 1'b1);
    spc_host_i.send(8'h45, 8);
    wt(1, 1'b1, 100);
    chk(stby, 1'b1);
    hot <= 1'b0;
    play(8'h01);
    repeat (60) @(posedge clk);
    chk(fault, 1'b1);
    // Second reset: LSB first, clock idling high
    rst_n <= 1'b0;
    alt <= 1'b1;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    spc_host_i.send(8'hA0, 8);
    wt(0, 1'b0, 20);
    chk(evt, 6'h05);
    end_sim;
  end
  initial begin
    #300000;
    num_errors++;
    end_sim;
  end
endmodule // speech_player_serial_control_tb
`default_nettype wire
